/* File: src/prbs_irq_map.svh */
// Register offsets, field positions, reset values and counts of the block
`ifndef PRBS_IRQ_MAP_SVH
`define PRBS_IRQ_MAP_SVH

// ****************************************************************
// Register addresses on the serial port
// ****************************************************************
`define ADDR_PATTERN_SEL   15'h0014
`define ADDR_CHIP_EN       15'h0020
`define ADDR_CHIP_STAT     15'h0024
`define ADDR_CHK_CTRL      15'h014b
`define ADDR_I_ERRCNT      15'h014c
`define ADDR_Q_ERRCNT      15'h014d
`define ADDR_LINK_0        15'h0470
`define ADDR_LINK_1        15'h0471
`define ADDR_LINK_2        15'h0472
`define ADDR_LINK_3        15'h0473
`define ADDR_LANE_EN_0     15'h04b8
`define ADDR_LANE_EN_1     15'h04b9
`define ADDR_LANE_ST_0     15'h04ba
`define ADDR_LANE_ST_1     15'h04bb

// ****************************************************************
// Field positions
// ****************************************************************
`define PAT_SEL_BIT        2
`define CHK_EN_BIT         0
`define CHK_RST_BIT        1
`define I_PASS_BIT         6
`define Q_PASS_BIT         7
`define I_FAIL_EVT         0
`define Q_FAIL_EVT         1

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BYTE           8'h00
`define RST_CTRL           2'h0

// ****************************************************************
// Frame and pattern counts
// ****************************************************************
`define SPI_HDR_LAST       5'h0f
`define SPI_FRAME_LAST     5'h17
`define PRBS7_TAP_A        7
`define PRBS7_TAP_B        6
`define PRBS15_TAP_A       15
`define PRBS15_TAP_B       14
`define MAX_EVENTS         75

`endif

/* File: src/prbs_irq_pkg.sv */
// Types shared by the checker and interrupt block
package prbs_irq_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_HDR  = 2'b01,
      SPI_DATA = 2'b10
   } spi_state_e;

   typedef struct packed {
      logic        sclk;
      spi_state_e  st;
      logic [4:0]  bit_cnt;
      logic [15:0] hdr;
      byte_t       wdat;
      byte_t       rdsh;
      logic        sdo;
      logic        sdo_oe;
      byte_t       pat_cfg;
      logic [1:0]  chk_ctrl;
      byte_t       chip_en;
      byte_t       chip_src;
      byte_t       chip_prev;
      logic [31:0] link_en;
      logic [31:0] link_src;
      logic [31:0] link_prev;
      logic [15:0] lane_en;
      logic [15:0] lane_src;
      logic [15:0] lane_prev;
      logic        irq_oe;
      logic        irq_lvl;
   } irq_state_s;

endpackage

/* File: src/prbs_word_checker.sv */
// Self-synchronising PRBS7/PRBS15 checker for one data path
`timescale 1ns/1ns
`include "prbs_irq_map.svh"
module prbs_word_checker #(
   parameter int WORD_W = 32,
   parameter int CNT_W  = 8
) (
   // Clock and reset
   input  logic              sys_clk,
   input  logic              reset,
   // Control
   input  logic              run,
   input  logic              hold,
   input  logic              prbs15,
   // Received word
   input  logic [WORD_W-1:0] data,
   input  logic              valid,
   // Results
   output logic [CNT_W-1:0]  err_cnt,
   output logic              fail
);

   // Taps reach fifteen bits back; the count is one byte at most
   if (WORD_W < 16 || CNT_W < 1 || CNT_W > 8) begin : g_bad_size
      $error("prbs_word_checker: unsupported WORD_W or CNT_W");
   end

   typedef struct packed {
      logic [WORD_W-1:0] prev;
      logic              have_prev;
      logic [CNT_W-1:0]  cnt;
      logic              seen;
   } chk_state_s;

   chk_state_s q;
   chk_state_s d;

   // ****************************************************************
   // Prediction of each new bit from the bits before it
   // ****************************************************************
   always_comb begin
      logic [2*WORD_W-1:0] t;
      logic                mis;
      logic                expd;
      t    = '0;
      mis  = 1'b0;
      expd = 1'b0;
      d    = q;
      // Oldest bit first: previous word then new word, MSB first
      for (int k = 0; k < WORD_W; k++) begin
         t[k]        = q.prev[WORD_W-1-k];
         t[WORD_W+k] = data[WORD_W-1-k];
      end
      for (int k = WORD_W; k < 2*WORD_W; k++) begin
         if (prbs15) begin
            expd = t[k-`PRBS15_TAP_A] ^ t[k-`PRBS15_TAP_B];
         end else begin
            expd = t[k-`PRBS7_TAP_A] ^ t[k-`PRBS7_TAP_B];
         end
         mis = mis | (expd ^ t[k]);
      end
      if (hold) begin
         d = '0;
      end else if (run && valid) begin
         d.prev      = data;
         d.have_prev = 1'b1;
         // One count per word however many bits differ
         if (q.have_prev && mis) begin
            d.seen = 1'b1;
            if (q.cnt != {CNT_W{1'b1}}) begin
               d.cnt = q.cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign err_cnt = q.cnt;
   assign fail    = q.seen;

endmodule

/* File: src/datapath_prbs_check_and_irq.sv */
// Serial register port, datapath PRBS checkers and event interrupt logic
`timescale 1ns/1ns
`include "prbs_irq_map.svh"
module datapath_prbs_check_and_irq #(
   parameter int WORD_W    = 32,
   parameter int CHIP_EVTS = 8,
   parameter int LINK_EVTS = 32,
   parameter int LANE_EVTS = 16
) (
   // Clock and reset
   input  logic              sys_clk,
   input  logic              reset,
   // Serial control port
   input  logic              spi_sclk,
   input  logic              spi_cs_n,
   input  logic              spi_sdi,
   output logic              spi_sdo,
   output logic              spi_sdo_oe,
   // Received datapath words
   input  logic [WORD_W-1:0] i_data,
   input  logic [WORD_W-1:0] q_data,
   input  logic              data_valid,
   // Event inputs
   input  logic [7:2]        chip_event_in,
   input  logic [31:0]       link_event_in,
   input  logic [15:0]       lane_event_in,
   // Open-drain alert
   output logic              irq_n_out,
   output logic              irq_n_oe
);

   // Register widths are fixed by the map
   if (CHIP_EVTS != 8 || LINK_EVTS != 32 || LANE_EVTS != 16) begin : g_bad_map
      $error("datapath_prbs_check_and_irq: bad event counts");
   end
   // Total of monitored events is bounded
   if (CHIP_EVTS + LINK_EVTS + LANE_EVTS > `MAX_EVENTS) begin : g_too_many
      $error("datapath_prbs_check_and_irq: too many events");
   end
   // Checker words are one 32-bit group
   if (WORD_W != 32) begin : g_bad_word
      $error("datapath_prbs_check_and_irq: WORD_W must be 32");
   end

   prbs_irq_pkg::irq_state_s q;
   prbs_irq_pkg::irq_state_s d;

   logic [7:0] i_cnt;
   logic [7:0] q_cnt;
   logic       i_fail;
   logic       q_fail;
   logic       chk_run;
   logic       chk_hold;
   logic       pat15;

   // ****************************************************************
   // Checker control decode
   // ****************************************************************
   // 11 runs with state held cleared, 01 runs free
   assign chk_run  = q.chk_ctrl[`CHK_EN_BIT];
   assign chk_hold = q.chk_ctrl[`CHK_RST_BIT];
   assign pat15    = q.pat_cfg[`PAT_SEL_BIT];

   // ****************************************************************
   // In-phase and quadrature checkers
   // ****************************************************************
   prbs_word_checker #(
      .WORD_W (WORD_W),
      .CNT_W  (8)
   ) i_checker (
      .sys_clk (sys_clk),
      .reset   (reset),
      .run     (chk_run),
      .hold    (chk_hold),
      .prbs15  (pat15),
      .data    (i_data),
      .valid   (data_valid),
      .err_cnt (i_cnt),
      .fail    (i_fail)
   );

   prbs_word_checker #(
      .WORD_W (WORD_W),
      .CNT_W  (8)
   ) q_checker (
      .sys_clk (sys_clk),
      .reset   (reset),
      .run     (chk_run),
      .hold    (chk_hold),
      .prbs15  (pat15),
      .data    (q_data),
      .valid   (data_valid),
      .err_cnt (q_cnt),
      .fail    (q_fail)
   );

   // ****************************************************************
   // Event vectors
   // ****************************************************************
   logic [7:0] chip_ev;
   always_comb begin
      chip_ev              = {chip_event_in, 2'b00};
      chip_ev[`I_FAIL_EVT] = i_fail;
      chip_ev[`Q_FAIL_EVT] = q_fail;
   end

   // ****************************************************************
   // Register readback
   // ****************************************************************
   function automatic prbs_irq_pkg::byte_t read_reg(
      input logic [14:0] addr,
      input prbs_irq_pkg::irq_state_s s,
      input logic [7:0] cev,
      input logic [7:0] ic,
      input logic [7:0] qc,
      input logic if_, input logic qf_);
      prbs_irq_pkg::byte_t r;
      r = `RST_BYTE;
      unique case (addr)
         `ADDR_PATTERN_SEL: r = s.pat_cfg;
         `ADDR_CHIP_EN:     r = s.chip_en;
         // Latched source if enabled, otherwise the live event
         `ADDR_CHIP_STAT:
            r = (s.chip_en & s.chip_src) | (~s.chip_en & cev);
         `ADDR_CHK_CTRL: begin
            r = {6'h00, s.chk_ctrl};
            r[`I_PASS_BIT] = ~if_;
            r[`Q_PASS_BIT] = ~qf_;
         end
         `ADDR_I_ERRCNT:    r = ic;
         `ADDR_Q_ERRCNT:    r = qc;
         `ADDR_LINK_0:      r = s.link_src[7:0] & s.link_en[7:0];
         `ADDR_LINK_1:      r = s.link_src[15:8] & s.link_en[15:8];
         `ADDR_LINK_2:      r = s.link_src[23:16] & s.link_en[23:16];
         `ADDR_LINK_3:      r = s.link_src[31:24] & s.link_en[31:24];
         `ADDR_LANE_ST_0:   r = s.lane_src[7:0] & s.lane_en[7:0];
         `ADDR_LANE_ST_1:   r = s.lane_src[15:8] & s.lane_en[15:8];
         default:           r = `RST_BYTE;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic        rise_sclk;
      logic        fall_sclk;
      logic        wr;
      logic [14:0] waddr;
      logic [7:0]  wbyte;
      logic [7:0]  chip_rst;
      logic [31:0] link_rst;
      logic [15:0] lane_rst;
      rise_sclk = 1'b0;
      fall_sclk = 1'b0;
      wr        = 1'b0;
      waddr     = '0;
      wbyte     = '0;
      chip_rst  = '0;
      link_rst  = '0;
      lane_rst  = '0;
      d         = q;

      // Serial frame: R/W, 15 address bits, 8 data bits, MSB first
      d.sclk    = spi_sclk;
      rise_sclk = spi_sclk & ~q.sclk;
      fall_sclk = ~spi_sclk & q.sclk;
      if (spi_cs_n) begin
         d.st      = prbs_irq_pkg::SPI_IDLE;
         d.bit_cnt = '0;
         d.sdo_oe  = 1'b0;
         d.sdo     = 1'b0;
      end else begin
         unique case (q.st)
            prbs_irq_pkg::SPI_IDLE: begin
               d.st = prbs_irq_pkg::SPI_HDR;
               if (rise_sclk) begin
                  d.hdr     = {q.hdr[14:0], spi_sdi};
                  d.bit_cnt = 5'h01;
               end
            end
            prbs_irq_pkg::SPI_HDR: begin
               if (rise_sclk) begin
                  d.hdr     = {q.hdr[14:0], spi_sdi};
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == `SPI_HDR_LAST) begin
                     d.st   = prbs_irq_pkg::SPI_DATA;
                     d.rdsh = read_reg({q.hdr[13:0], spi_sdi}, q,
                                       chip_ev, i_cnt, q_cnt,
                                       i_fail, q_fail);
                  end
               end
            end
            prbs_irq_pkg::SPI_DATA: begin
               if (rise_sclk && q.bit_cnt <= `SPI_FRAME_LAST) begin
                  d.wdat    = {q.wdat[6:0], spi_sdi};
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == `SPI_FRAME_LAST && !q.hdr[15]) begin
                     wr    = 1'b1;
                     waddr = q.hdr[14:0];
                     wbyte = {q.wdat[6:0], spi_sdi};
                  end
               end
               // Read data shifted out on falling edges
               if (fall_sclk && q.hdr[15]) begin
                  d.sdo    = q.rdsh[7];
                  d.rdsh   = {q.rdsh[6:0], 1'b0};
                  d.sdo_oe = 1'b1;
               end
            end
            default: d.st = prbs_irq_pkg::SPI_IDLE;
         endcase
      end

      // Register writes and their side effects
      if (wr) begin
         unique case (waddr)
            `ADDR_PATTERN_SEL: d.pat_cfg = wbyte;
            `ADDR_CHIP_EN:     d.chip_en = wbyte;
            `ADDR_CHIP_STAT:   chip_rst = wbyte;
            `ADDR_CHK_CTRL:    d.chk_ctrl = wbyte[1:0];
            // Link byte sets enables; a 1 on an enabled bit resets it
            `ADDR_LINK_0: begin
               d.link_en[7:0]  = wbyte;
               link_rst[7:0]   = wbyte & q.link_en[7:0];
            end
            `ADDR_LINK_1: begin
               d.link_en[15:8] = wbyte;
               link_rst[15:8]  = wbyte & q.link_en[15:8];
            end
            `ADDR_LINK_2: begin
               d.link_en[23:16] = wbyte;
               link_rst[23:16]  = wbyte & q.link_en[23:16];
            end
            `ADDR_LINK_3: begin
               d.link_en[31:24] = wbyte;
               link_rst[31:24]  = wbyte & q.link_en[31:24];
            end
            `ADDR_LANE_EN_0:   d.lane_en[7:0] = wbyte;
            `ADDR_LANE_EN_1:   d.lane_en[15:8] = wbyte;
            `ADDR_LANE_ST_0:   lane_rst[7:0] = wbyte;
            `ADDR_LANE_ST_1:   lane_rst[15:8] = wbyte;
            default: ;
         endcase
      end

      // Edge latch: set beats reset, disable forces zero
      d.chip_prev = chip_ev;
      d.link_prev = link_event_in;
      d.lane_prev = lane_event_in;
      d.chip_src  = d.chip_en & ((chip_ev & ~q.chip_prev) |
                    (q.chip_src & ~chip_rst));
      d.link_src  = d.link_en & ((link_event_in & ~q.link_prev) |
                    (q.link_src & ~link_rst));
      d.lane_src  = d.lane_en & ((lane_event_in & ~q.lane_prev) |
                    (q.lane_src & ~lane_rst));

      // Alert driven low only, released otherwise
      d.irq_oe  = |{d.chip_src, d.link_src, d.lane_src};
      d.irq_lvl = 1'b0;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign spi_sdo    = q.sdo;
   assign spi_sdo_oe = q.sdo_oe;
   assign irq_n_out  = q.irq_lvl;
   assign irq_n_oe   = q.irq_oe;

endmodule

/* File: dv/prbs_irq_monitor.sv */
// Port assertions for the PRBS checker and alert block
`timescale 1ns/1ns
module prbs_irq_monitor #(
   parameter int WORD_W = 32
) (
   // Clock and reset
   input logic              sys_clk,
   input logic              reset,
   // Serial port
   input logic              spi_sclk,
   input logic              spi_cs_n,
   input logic              spi_sdi,
   input logic              spi_sdo,
   input logic              spi_sdo_oe,
   // Datapath and events
   input logic [WORD_W-1:0] i_data,
   input logic [WORD_W-1:0] q_data,
   input logic              data_valid,
   input logic [7:2]        chip_event_in,
   input logic [31:0]       link_event_in,
   input logic [15:0]       lane_event_in,
   // Alert
   input logic              irq_n_out,
   input logic              irq_n_oe
);
   logic [53:0] ev;
   logic [53:0] ev_q;
   logic [4:0]  rise_q;
   logic [5:0]  dv_q;
   logic [3:0]  sclk_q;
   logic        fall_win;
   assign ev = {chip_event_in, link_event_in, lane_event_in};
   assign fall_win = |(sclk_q[3:1] & ~sclk_q[2:0]);
   // ********
   // Recent causes of output changes
   // ********
   always_ff @(posedge sys_clk) begin
      ev_q   <= ev;
      rise_q <= {rise_q[3:0], |(ev & ~ev_q)};
      dv_q   <= {dv_q[4:0], data_valid};
      sclk_q <= {sclk_q[2:0], spi_sclk};
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_alert_never_high: assert property (!irq_n_out)
      else $error("alert data high");
   a_reset_clears: assert property (disable iff (1'b0)
      reset |=> !irq_n_oe && !spi_sdo_oe) else $error("reset kept outputs");
   a_alert_cause: assert property ($rose(irq_n_oe)
      |-> |rise_q || |dv_q) else $error("alert without event");
   a_alert_release: assert property ($fell(irq_n_oe)
      |-> $past(reset) || !$past(spi_cs_n, 2)) else $error("alert dropped");
   a_alert_held: assert property ((irq_n_oe && spi_cs_n)[*3]
      |=> irq_n_oe) else $error("alert lost");
   a_oe_frame_end: assert property (spi_cs_n && $past(spi_cs_n)
      |-> !spi_sdo_oe) else $error("sdo driven idle");
   a_oe_in_frame: assert property ($rose(spi_sdo_oe)
      |-> !spi_cs_n && !$past(spi_cs_n, 32)) else $error("sdo early");
   a_sdo_on_fall: assert property (spi_sdo_oe && $changed(spi_sdo)
      |-> fall_win) else $error("sdo moved off edge");
   c_alert: cover property ($rose(irq_n_oe));
   c_read: cover property ($rose(spi_sdo_oe));
   c_words: cover property (data_valid [*8]);
endmodule

bind datapath_prbs_check_and_irq prbs_irq_monitor #(.WORD_W(WORD_W)) u_mon (
   .sys_clk(sys_clk), .reset(reset), .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
   .spi_sdo_oe(spi_sdo_oe), .i_data(i_data), .q_data(q_data),
   .data_valid(data_valid), .chip_event_in(chip_event_in),
   .link_event_in(link_event_in), .lane_event_in(lane_event_in),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

/* File: dv/spi_host_model.sv */
// Host model: serial register frames and the pulled-up alert wire
`timescale 1ns/1ns
module spi_host_model (
   // Clock
   input  logic sys_clk,
   // Serial port
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input  logic spi_sdo,
   input  logic spi_sdo_oe,
   // Alert
   input  logic irq_n_out,
   input  logic irq_n_oe,
   output logic irq_line
);
   int   half = 3;
   logic sdo_last = 1'b0;
   logic sdo_line;
   // Pull-up on alert; released data line reads the inverse of its last level
   assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
   assign sdo_line = spi_sdo_oe ? spi_sdo : ~sdo_last;
   always @(posedge sys_clk) if (spi_sdo_oe) sdo_last <= spi_sdo;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One frame: R/W, 15 address bits, 8 data bits, MSB first
   task automatic xfer(input logic rw, input logic [14:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
      logic [23:0] f;
      f = {rw, a, wd};
      rd = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = f[i];
         step(half);
         if (i < 8) rd[i] = sdo_line;
         spi_sclk = 1'b1;
         step(half);
         spi_sclk = 1'b0;
      end
      step(half);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      step(half);
   endtask
endmodule

/* File: dv/datapath_prbs_check_and_irq_test.sv */
// Self-checking bench for the PRBS checker and alert block
`timescale 1ns/1ns
module datapath_prbs_check_and_irq_test;
   localparam int LIMIT = 60000;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [31:0] i_data = 32'h0;
   logic [31:0] q_data = 32'h0;
   logic        data_valid = 1'b0;
   logic [7:2]  chip_ev = 6'h0;
   logic [31:0] link_ev = 32'h0;
   logic [15:0] lane_ev = 16'h0;
   logic [14:0] h = 15'h7fff;
   wire         spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   wire         irq_n_out, irq_n_oe, irq_line;
   int          errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   datapath_prbs_check_and_irq u_dut (
      .sys_clk(sys_clk), .reset(reset), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe), .i_data(i_data), .q_data(q_data),
      .data_valid(data_valid), .chip_event_in(chip_ev),
      .link_event_in(link_ev), .lane_event_in(lane_ev),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   spi_host_model u_host (
      .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         end_sim();
      end
   end
   // ********
   // Access and check tasks
   // ********
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] v;
      u_host.xfer(1'b0, a, d, v);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_host.xfer(1'b1, a, 8'h00, v);
      chk($sformatf("reg %h", a), v, exp);
   endtask
   task automatic alert(input logic exp);
      chk("alert", {7'h00, irq_line}, {7'h00, exp});
   endtask
   // Next pattern word, earliest bit in bit 31
   function automatic logic [31:0] nxt(input logic p15);
      logic [31:0] w;
      logic        b;
      for (int k = 31; k >= 0; k--) begin
         b = p15 ? h[13] ^ h[14] : h[5] ^ h[6];
         w[k] = b;
         h = {h[13:0], b};
      end
      return w;
   endfunction
   // Words with bit 0 flipped on I word bi, Q words bq and bq+1
   task automatic feed(input logic p15, input int n, bi, bq,
                       input logic ones);
      logic [31:0] w;
      for (int j = 0; j < n; j++) begin
         w = ones ? 32'hffffffff : nxt(p15);
         i_data = w ^ {31'h0, j == bi};
         q_data = w ^ {31'h0, j == bq || j == bq + 1};
         data_valid = 1'b1;
         step(1);
      end
      data_valid = 1'b0;
      step(4);
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      step(8);
      reset = 1'b0;
      step(2);
      u_host.half = 2;
      rd(15'h20, 8'h00);
      rd(15'h24, 8'h00);
      rd(15'h14, 8'h00);
      rd(15'h14b, 8'hc0);
      rd(15'h14c, 8'h00);
      rd(15'h14d, 8'h00);
      rd(15'h4b8, 8'h00);
      rd(15'h100, 8'h00);
      u_host.half = 3;
      $display("test reset_values done");
      wr(15'h14, 8'ha5);
      rd(15'h14, 8'ha5);
      wr(15'h20, 8'h04);
      rd(15'h20, 8'h04);
      chip_ev = 6'h03;
      step(3);
      alert(1'b0);
      chk("alert_data", {7'h00, irq_n_out}, 8'h00);
      rd(15'h24, 8'h0c);
      chip_ev = 6'h00;
      step(1);
      rd(15'h24, 8'h04);
      wr(15'h24, 8'h04);
      rd(15'h24, 8'h00);
      alert(1'b1);
      chip_ev = 6'h01;
      step(3);
      alert(1'b0);
      rd(15'h24, 8'h04);
      wr(15'h20, 8'h00);
      alert(1'b1);
      rd(15'h24, 8'h04);
      wr(15'h24, 8'h04);
      wr(15'h20, 8'h04);
      alert(1'b1);
      chip_ev = 6'h00;
      $display("test chip_events done");
      for (int k = 0; k < 4; k++) wr(15'(15'h470 + k), 8'(8'h01 << k));
      wr(15'h4b8, 8'h01);
      wr(15'h4b9, 8'h80);
      link_ev = 32'hffffffff;
      lane_ev = 16'hffff;
      step(3);
      alert(1'b0);
      for (int k = 0; k < 4; k++) begin
         rd(15'(15'h470 + k), 8'(8'h01 << k));
         wr(15'(15'h470 + k), 8'(8'h01 << k));
         rd(15'(15'h470 + k), 8'h00);
      end
      rd(15'h4ba, 8'h01);
      rd(15'h4bb, 8'h80);
      rd(15'h4b9, 8'h00);
      wr(15'h4ba, 8'h01);
      wr(15'h4bb, 8'h80);
      rd(15'h4bb, 8'h00);
      alert(1'b1);
      lane_ev = 16'h0;
      step(1);
      lane_ev = 16'h0001;
      step(3);
      alert(1'b0);
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      step(2);
      alert(1'b1);
      rd(15'h4ba, 8'h00);
      rd(15'h20, 8'h00);
      lane_ev = 16'h0;
      step(1);
      lane_ev = 16'h0001;
      step(3);
      alert(1'b1);
      link_ev = 32'h0;
      lane_ev = 16'h0;
      $display("test link_lane done");
      wr(15'h20, 8'h03);
      wr(15'h14, 8'h00);
      wr(15'h14b, 8'h03);
      wr(15'h14b, 8'h01);
      feed(1'b0, 20, 8, 12, 1'b0);
      step(20); // Shortened settle before results
      rd(15'h14c, 8'h02);
      rd(15'h14d, 8'h03);
      rd(15'h14b, 8'h01);
      rd(15'h24, 8'h03);
      alert(1'b0);
      wr(15'h24, 8'h03);
      rd(15'h24, 8'h00);
      wr(15'h14, 8'h04);
      wr(15'h14b, 8'h03);
      rd(15'h14b, 8'hc3);
      rd(15'h14c, 8'h00);
      wr(15'h14b, 8'h01);
      feed(1'b1, 40, -9, -9, 1'b0);
      rd(15'h14c, 8'h00);
      rd(15'h14d, 8'h00);
      rd(15'h14b, 8'hc1);
      feed(1'b1, 20, -9, 5, 1'b0);
      rd(15'h14b, 8'h41);
      rd(15'h14c, 8'h00);
      rd(15'h14d, 8'h03);
      rd(15'h24, 8'h02);
      feed(1'b1, 300, -9, -9, 1'b1);
      rd(15'h14c, 8'hff);
      rd(15'h14d, 8'hff);
      rd(15'h24, 8'h03);
      $display("test prbs done");
      end_sim();
   end
endmodule
